// [rtl/cac_map.vh]
// constants for the charge accounting core: full counts, thresholds, reset values, timing
// assumes a 20 MHz clock and a sense measurement given in microvolts, signed
`ifndef CAC_MAP_VH
`define CAC_MAP_VH
`define CAC_FULL_SH_PH 16'h9D00
`define CAC_FULL_SZ_PH 16'h7E00
`define CAC_FULL_SL_PH 16'h7100
`define CAC_FULL_SH_PL 16'h6500
`define CAC_FULL_SZ_PL 16'h8C00
`define CAC_FULL_SL_PL 16'h5B00
`define CAC_ZERO16 16'h0000
`define CAC_MAX16 16'hFFFF
`define CAC_CHG_THR_UV (-400)
`define CAC_DSG_THR_UV 500
`define CAC_DISP_THR_UV 2000
`define CAC_VALID_CHG_COUNTS 16'h0100
`define CAC_SELF_DSG_LIMIT 16'h1000
`define CAC_TEMP_STEP_ZERO_C 4'h4
`define CAC_TEMP_STEP_30C 4'h7
`define CAC_TEMP_STEP_50C 4'h9
`define CAC_TEMP_STEP_10C 4'h5
`define CAC_CLK_HZ 20000000
`define CAC_SEC_CYCLES (`CAC_CLK_HZ)
`define CAC_DISP_HOLD_S 10
`define CAC_FAST_RATE 2
// efficiency factors in 1/100 units
`define CAC_EFF_TR_NOM 7'h50
`define CAC_EFF_TR_WRM 7'h4B
`define CAC_EFF_TR_HOT 7'h46
`define CAC_EFF_FS_NOM 7'h5F
`define CAC_EFF_FS_WRM 7'h5A
`define CAC_EFF_FS_HOT 7'h55
`define CAC_EFF_UNITY 7'h64
`define CAC_HUNDRED 8'h64
`endif

// [rtl/cac_frac_acc.v]
// fractional accumulator: adds weight per event, emits one whole count per hundred
// assumes events arrive as single-cycle pulses on the shared clock
`timescale 1ns/1ps
`include "cac_map.vh"
module cac_frac_acc (
	// clock and reset
	input wire clock,
	input wire rst_b,
	// event in
	input wire event_in,
	input wire [6:0] weight,
	// whole count out
	output reg count_out
);
	reg [7:0] acc;
	wire [7:0] sum = acc + {1'b0, weight};
	always @(posedge clock) begin
		count_out <= 1'b0;
		if (!rst_b) begin
			acc <= 8'h00;
		end else if (event_in) begin
			if (sum >= `CAC_HUNDRED) begin
				acc <= sum - `CAC_HUNDRED;
				count_out <= 1'b1;
			end else begin
				acc <= sum;
			end
		end
	end
endmodule // cac_frac_acc

// [rtl/cac_sync2.v]
// two flop synchroniser for pin-side levels
// assumes the input is asynchronous to clock
`timescale 1ns/1ps
module cac_sync2 #(parameter W = 1) (
	// clock
	input wire clock,
	// level
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta;
	// no reset: straps keep flowing during reset so init reads settled levels, not zeros
	always @(posedge clock) begin
		meta <= d;
		q <= meta;
	end
endmodule // cac_sync2

// [rtl/cac_core.v]
// charge accounting core: available charge, discharge count, learned capacity
// assumes sense voltage, temperature step and event ticks come from same-clock logic;
// strap pins are asynchronous and pass two flops.
// Overview of operation
// - available charge rises to learned capacity, falls to zero, never past either
// - available charge clears at init and on first valid charge after end-of-discharge
// - self-discharge strap low loads full count, disables self-discharge; else zero, enabled
// - initial full count picked from scale pin and program pin one, absolute mode
// - discharge counter grows independently; self-discharge counts only while charge nonzero
// - discharge counter clears while available charge equals learned capacity, but loads one when a count leaves full
// - discharge counter saturates at FFFF and never wraps
// - first charge after valid discharge copies discharge counter into learned capacity
// - learning also needs accumulated self-discharge of at most 4096 counts
// - learning also needs temperature at or above zero at end-of-discharge detection
// - valid discharge flag shows whether present discharge still qualifies for learning
// - charging counts proportionally after compensation; below -2 mV requests display
// - charge valid after more than 256 counts below -400 uV, ends above it
// - above 500 uV each discharge count decrements charge and increments discharge counter
// - discharge above 2 mV requests display, held ten seconds after dropping below
// - enabled self-discharge lowers charge and raises discharge counter by time and temperature
// - self-discharge rate over eight bands, doubling per ten degrees, 320 down to 2.5
// - fast charge at two or more counts per second; fast factor until rate known
// - charge efficiency by three temperature bands, trickle and fast factors
// - discharge counting uses a factor of exactly one
// - filter suppresses counting between -400 and +500 microvolts
// - learned capacity loads programmed full count at initialisation
// - ten-degree temperature steps select compensation, self-discharge rate, learning qualification
`timescale 1ns/1ps
`include "cac_map.vh"
module cac_core #(
	parameter SEC_CYCLES = `CAC_SEC_CYCLES,
	parameter SD_BASE_CYCLES = 1080000
) (
	// clock and reset
	input wire clock,
	input wire rst_b,
	// serial reset command, one-cycle pulse
	input wire init_cmd,
	// strap pins, three-level pin as high/float flags
	input wire scale_select_pin_high,
	input wire scale_select_pin_float,
	input wire program_pin_one,
	input wire self_discharge_strap,
	// measurement
	input wire signed [17:0] corrected_sense_voltage,
	input wire count_tick,
	input wire [3:0] temperature_step,
	input wire end_of_discharge_level,
	input wire display_enable,
	// results
	output reg [15:0] available_charge,
	output reg [15:0] discharge_counter,
	output reg [15:0] learned_capacity,
	output reg [15:0] initial_full_count,
	output reg valid_discharge_flag,
	output reg self_discharge_enabled,
	output reg display_request,
	output reg fast_charge
);
	localparam [31:0] HOLD_CYCLES = `CAC_DISP_HOLD_S * SEC_CYCLES;
	localparam [1:0] ST_INIT = 2'h0;
	localparam [1:0] ST_LOAD = 2'h1;
	localparam [1:0] ST_RUN = 2'h2;

	wire [3:0] pins;
	cac_sync2 #(.W(4)) u_sync (
		.clock(clock),
		.d({scale_select_pin_high, scale_select_pin_float, program_pin_one, self_discharge_strap}),
		.q(pins)
	);

	reg [1:0] state;
	reg [1:0] next_state;
	reg [15:0] next_full;
	reg [6:0] chg_weight;
	reg [2:0] sd_shift;
	wire chg_zone = corrected_sense_voltage < `CAC_CHG_THR_UV;
	wire dsg_zone = corrected_sense_voltage > `CAC_DSG_THR_UV;
	wire chg_disp = corrected_sense_voltage < -`CAC_DISP_THR_UV;
	wire dsg_fast = corrected_sense_voltage > `CAC_DISP_THR_UV;
	wire chg_event = count_tick && chg_zone;
	wire dsg_event = count_tick && dsg_zone;
	wire chg_count;
	wire dsg_count;
	reg sd_tick;

	// full count table, strap pins read only after sync
	always @* begin
		case ({pins[3], pins[2], pins[1]})
			3'b101, 3'b111: next_full = `CAC_FULL_SH_PH;
			3'b011: next_full = `CAC_FULL_SZ_PH;
			3'b001: next_full = `CAC_FULL_SL_PH;
			3'b100, 3'b110: next_full = `CAC_FULL_SH_PL;
			3'b010: next_full = `CAC_FULL_SZ_PL;
			default: next_full = `CAC_FULL_SL_PL;
		endcase
	end

	// charge efficiency by band and rate; fast factor until rate is known
	always @* begin
		if (temperature_step < `CAC_TEMP_STEP_30C) begin
			chg_weight = fast_charge ? `CAC_EFF_FS_NOM : `CAC_EFF_TR_NOM;
		end else if (temperature_step < `CAC_TEMP_STEP_50C) begin
			chg_weight = fast_charge ? `CAC_EFF_FS_WRM : `CAC_EFF_TR_WRM;
		end else begin
			chg_weight = fast_charge ? `CAC_EFF_FS_HOT : `CAC_EFF_TR_HOT;
		end
	end

	cac_frac_acc u_chg (
		.clock(clock),
		.rst_b(rst_b),
		.event_in(chg_event),
		.weight(chg_weight),
		.count_out(chg_count)
	);

	cac_frac_acc u_dsg (
		.clock(clock),
		.rst_b(rst_b),
		.event_in(dsg_event),
		.weight(`CAC_EFF_UNITY),
		.count_out(dsg_count)
	);

	// self-discharge timebase: period halves each band above 0-10 C up to step B, fixed above it
	always @* begin
		if (temperature_step < `CAC_TEMP_STEP_10C) begin
			sd_shift = 3'h0;
		end else if (temperature_step > 4'hB) begin
			sd_shift = 3'h7;
		end else begin
			sd_shift = temperature_step[2:0] - 3'h4;
		end
	end
	reg [31:0] sd_timer;
	wire [31:0] sd_period = ((SD_BASE_CYCLES << 3) >> sd_shift);
	wire [31:0] sd_scaled = sd_period / ((available_charge == `CAC_ZERO16) ? 32'h1 : {16'h0, available_charge});
	always @(posedge clock) begin
		sd_tick <= 1'b0;
		if (!rst_b || state != ST_RUN || !self_discharge_enabled) begin
			sd_timer <= 32'h0;
		end else if (sd_timer >= sd_scaled) begin
			sd_timer <= 32'h0;
			sd_tick <= 1'b1;
		end else begin
			sd_timer <= sd_timer + 32'h1;
		end
	end

	// init sequencing: strap is sampled in ST_LOAD at the second clock after release, never during reset
	always @* begin
		case (state)
			ST_INIT: next_state = ST_LOAD;
			ST_LOAD: next_state = ST_RUN;
			ST_RUN: next_state = init_cmd ? ST_INIT : ST_RUN;
			default: next_state = ST_INIT;
		endcase
	end

	reg [15:0] chg_run;
	reg chg_valid;
	reg eod_seen;
	reg charged_since_full;
	reg [15:0] sd_total;
	reg cold_at_eod;
	reg [31:0] rate_timer;
	reg [15:0] rate_cnt;
	reg [31:0] hold_timer;
	wire at_full = available_charge == learned_capacity;

	always @(posedge clock) begin
		if (!rst_b) begin
			state <= ST_INIT;
			available_charge <= `CAC_ZERO16;
			discharge_counter <= `CAC_ZERO16;
			learned_capacity <= `CAC_ZERO16;
			initial_full_count <= `CAC_ZERO16;
			self_discharge_enabled <= 1'b0;
			valid_discharge_flag <= 1'b0;
			chg_run <= `CAC_ZERO16;
			chg_valid <= 1'b0;
			eod_seen <= 1'b0;
			charged_since_full <= 1'b0;
			sd_total <= `CAC_ZERO16;
			cold_at_eod <= 1'b0;
		end else begin
			state <= next_state;
			if (state == ST_INIT) begin
				available_charge <= `CAC_ZERO16;
				discharge_counter <= `CAC_ZERO16;
				initial_full_count <= next_full;
				learned_capacity <= next_full;
				chg_run <= `CAC_ZERO16;
				chg_valid <= 1'b0;
				eod_seen <= 1'b0;
				charged_since_full <= 1'b0;
				sd_total <= `CAC_ZERO16;
				cold_at_eod <= 1'b0;
				valid_discharge_flag <= 1'b0;
			end else if (state == ST_LOAD) begin
				self_discharge_enabled <= pins[0];
				available_charge <= pins[0] ? `CAC_ZERO16 : initial_full_count;
			end else begin
				// charge validity: run length of counts in the charge zone
				if (!chg_zone) begin
					chg_run <= `CAC_ZERO16;
					chg_valid <= 1'b0;
				end else if (chg_count && chg_run != `CAC_MAX16) begin
					chg_run <= chg_run + 16'h1;
					if (chg_run >= `CAC_VALID_CHG_COUNTS) begin
						chg_valid <= 1'b1;
					end
				end
				if (end_of_discharge_level && !eod_seen && dsg_zone) begin
					eod_seen <= 1'b1;
					cold_at_eod <= temperature_step < `CAC_TEMP_STEP_ZERO_C;
				end
				if (chg_valid && !eod_seen && !at_full) begin
					charged_since_full <= 1'b1;
				end
				if (chg_valid && eod_seen) begin
					// first valid charge after end-of-discharge
					available_charge <= `CAC_ZERO16;
					if (valid_discharge_flag) begin
						learned_capacity <= discharge_counter;
					end
					eod_seen <= 1'b0;
					valid_discharge_flag <= 1'b0;
				end else begin
					if (chg_count && available_charge < learned_capacity) begin
						available_charge <= available_charge + 16'h1;
					end else if ((dsg_count || sd_tick) && available_charge != `CAC_ZERO16) begin
						available_charge <= available_charge - 16'h1;
					end
					if (at_full) begin
						valid_discharge_flag <= 1'b1;
						charged_since_full <= 1'b0;
						sd_total <= `CAC_ZERO16;
						cold_at_eod <= 1'b0;
					end else begin
						valid_discharge_flag <= valid_discharge_flag && !charged_since_full
							&& sd_total <= `CAC_SELF_DSG_LIMIT && !cold_at_eod;
					end
				end
				if (at_full) begin
					// the count that leaves full opens the new discharge, so it is kept, not lost to the clear
					discharge_counter <= ((dsg_count || sd_tick) && available_charge != `CAC_ZERO16) ? 16'h0001
						: `CAC_ZERO16;
				end else if ((dsg_count || (sd_tick && available_charge != `CAC_ZERO16))
					&& discharge_counter != `CAC_MAX16) begin
					discharge_counter <= discharge_counter + 16'h1;
				end
				if (sd_tick && available_charge != `CAC_ZERO16 && sd_total != `CAC_MAX16) begin
					sd_total <= sd_total + 16'h1;
				end
			end
		end
	end

	// fast-charge detection: counts per one-second window; defaults fast
	always @(posedge clock) begin
		if (!rst_b || state != ST_RUN) begin
			rate_timer <= 32'h0;
			rate_cnt <= `CAC_ZERO16;
			fast_charge <= 1'b1;
		end else if (rate_timer >= SEC_CYCLES - 1) begin
			rate_timer <= 32'h0;
			rate_cnt <= `CAC_ZERO16;
			if (chg_zone) begin
				fast_charge <= rate_cnt >= `CAC_FAST_RATE;
			end else begin
				fast_charge <= 1'b1;
			end
		end else begin
			rate_timer <= rate_timer + 32'h1;
			if (chg_count && rate_cnt != `CAC_MAX16) begin
				rate_cnt <= rate_cnt + 16'h1;
			end
		end
	end

	// display request: ten second hold after fast discharge ends
	always @(posedge clock) begin
		if (!rst_b) begin
			hold_timer <= 32'h0;
			display_request <= 1'b0;
		end else if (!display_enable) begin
			hold_timer <= 32'h0;
			display_request <= 1'b0;
		end else if (dsg_fast || chg_disp) begin
			hold_timer <= HOLD_CYCLES;
			display_request <= 1'b1;
		end else if (hold_timer != 32'h0) begin
			hold_timer <= hold_timer - 32'h1;
			display_request <= 1'b1;
		end else begin
			display_request <= 1'b0;
		end
	end
endmodule // cac_core

// [tb/cac_core_monitor.sv]
// checker for cac_core: counter bounds, init loads, discharge walk, display
// assumes the core runs on one clock with synchronous active-low reset
`timescale 1ns/1ps
module cac_core_monitor (
	// clock and reset
	input wire clock,
	input wire rst_b,
	// inputs watched
	input wire init_cmd,
	input wire signed [17:0] corrected_sense_voltage,
	input wire count_tick,
	input wire display_enable,
	// outputs watched
	input wire [15:0] available_charge,
	input wire [15:0] discharge_counter,
	input wire [15:0] learned_capacity,
	input wire [15:0] initial_full_count,
	input wire self_discharge_enabled,
	input wire display_request
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	chk_charge_ceiling: assert property (available_charge <= learned_capacity)
		else $error("charge above capacity");
	chk_dcount_full_clear: assert property ((available_charge == learned_capacity)[*3] |-> discharge_counter == 16'h0000)
		else $error("discharge count not cleared at full");
	chk_dcount_no_wrap: assert property (discharge_counter == 16'hFFFF |=> discharge_counter inside {16'hFFFF, 16'h0000})
		else $error("discharge count wrapped");
	chk_quiet_hold: assert property ((!count_tick && !init_cmd && !self_discharge_enabled)[*5] |-> $stable(available_charge))
		else $error("charge moved without events");
	// one isolated tick brackets both possible pipeline depths
	chk_dsg_walk: assert property (!count_tick ##1 !count_tick ##1 (count_tick && corrected_sense_voltage > 18'sh001F4
		&& available_charge > 16'h0001 && !self_discharge_enabled && !init_cmd) ##1 !count_tick ##2 1
		|-> available_charge == $past(available_charge, 3) - 16'h0001) else $error("discharge step wrong");
	chk_disp_fast: assert property ((display_enable && count_tick && corrected_sense_voltage > 18'sh007D0)[*2]
		|-> ##[0:2] display_request) else $error("display not requested");
	chk_init_load: assert property ($rose(rst_b) ##2 1 |-> learned_capacity == initial_full_count
		&& initial_full_count inside {16'h9D00, 16'h7E00, 16'h7100, 16'h6500, 16'h8C00, 16'h5B00})
		else $error("capacity not loaded");
	chk_strap_load: assert property ($rose(rst_b) ##3 1 |-> (self_discharge_enabled ? available_charge == 16'h0000
		: available_charge == initial_full_count)) else $error("strap load wrong");
	cov_full_dsg: cover property (available_charge == learned_capacity ##1 available_charge < learned_capacity);
	cov_sat: cover property (discharge_counter == 16'hFFFF);
	cov_disp: cover property ($fell(display_request));
endmodule // cac_core_monitor
bind cac_core cac_core_monitor i_mon (.clock, .rst_b, .init_cmd, .corrected_sense_voltage, .count_tick,
	.display_enable, .available_charge, .discharge_counter, .learned_capacity, .initial_full_count,
	.self_discharge_enabled, .display_request);

// [tb/test_cac_core.sv]
// testbench for cac_core: straps, discharge, filter, display hold, learning, saturation
// assumes short SEC_CYCLES and SD_BASE_CYCLES so the run stays brief
`timescale 1ns/1ps
`include "cac_map.vh"
module test_cac_core;
	logic clock = 0, rst_b = 0, init_cmd = 0, pin_h = 0, pin_f = 0, p1 = 0, strap = 0;
	logic count_tick = 0, eod = 0, disp_en = 0;
	logic signed [17:0] volt = 0;
	logic [3:0] temp = 4'h6;
	wire [15:0] ac, dis_cnt, lc, full_cnt;
	wire vd_flag, sd_en, disp, fast;
	int n_fail = 0, checks = 0, cyc = 0;
	cac_core #(.SEC_CYCLES(100), .SD_BASE_CYCLES(200)) i_dut (.clock(clock), .rst_b(rst_b), .init_cmd(init_cmd),
		.scale_select_pin_high(pin_h), .scale_select_pin_float(pin_f), .program_pin_one(p1),
		.self_discharge_strap(strap), .corrected_sense_voltage(volt), .count_tick(count_tick),
		.temperature_step(temp), .end_of_discharge_level(eod), .display_enable(disp_en),
		.available_charge(ac), .discharge_counter(dis_cnt), .learned_capacity(lc), .initial_full_count(full_cnt),
		.valid_discharge_flag(vd_flag), .self_discharge_enabled(sd_en), .display_request(disp), .fast_charge(fast));
	initial forever #25 clock = ~clock;
	// ceiling sits well above the roughly 70000 cycles the tests need
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_fail = n_fail + 1;
			summarize;
		end
	end
	task summarize;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task do_reset(input logic h, input logic f, input logic p, input logic s);
		rst_b <= 0;
		pin_h <= h;
		pin_f <= f;
		p1 <= p;
		strap <= s;
		repeat (6) @(posedge clock);
		rst_b <= 1;
		repeat (4) @(posedge clock);
	endtask
	task ticks(input int n, input logic signed [17:0] v);
		volt <= v;
		count_tick <= 1;
		repeat (n) @(posedge clock);
		count_tick <= 0;
		repeat (4) @(posedge clock);
	endtask
	task t_full;
		logic [15:0] tbl [6] = '{`CAC_FULL_SH_PH, `CAC_FULL_SZ_PH, `CAC_FULL_SL_PH, `CAC_FULL_SH_PL, `CAC_FULL_SZ_PL,
			`CAC_FULL_SL_PL};
		for (int i = 0; i < 6; i++) begin
			do_reset(i % 3 == 0, i % 3 == 1, i < 3, 0);
			chk(full_cnt, tbl[i], "full count");
			chk(lc, tbl[i], "capacity");
			chk(ac, tbl[i], "strap low charge");
		end
		do_reset(0, 1, 1, 1);
		chk(ac, 16'h0000, "strap high charge");
		chk({15'h0000, sd_en}, 16'h0001, "self discharge on");
		chk({15'h0000, fast}, 16'h0001, "fast factor default");
		$display("test full count done");
	endtask
	task t_dsg;
		do_reset(0, 1, 1, 0);
		ticks(1, 18'sh00258);
		ticks(19, 18'sh00258);
		chk(ac, `CAC_FULL_SZ_PH - 16'h0014, "discharge");
		chk(dis_cnt, 16'h0014, "discharge count");
		ticks(20, 18'sh00000);
		ticks(20, -18'sh00190);
		ticks(20, 18'sh001F4);
		chk(ac, `CAC_FULL_SZ_PH - 16'h0014, "filtered");
		ticks(40, -18'sh003E8);
		chk(ac, `CAC_FULL_SZ_PH, "ceiling");
		chk(dis_cnt, 16'h0000, "discharge count clear");
		ticks(5, 18'sh00258);
		init_cmd <= 1;
		@(posedge clock);
		init_cmd <= 0;
		repeat (5) @(posedge clock);
		chk(ac, `CAC_FULL_SZ_PH, "reinit charge");
		chk(dis_cnt, 16'h0000, "reinit discharge count");
		$display("test discharge done");
	endtask
	task t_disp;
		disp_en <= 1;
		ticks(10, 18'sh009C4);
		chk({15'h0000, disp}, 16'h0001, "display on");
		ticks(10, 18'sh00258);
		repeat (800) @(posedge clock);
		chk({15'h0000, disp}, 16'h0001, "display held");
		repeat (400) @(posedge clock);
		chk({15'h0000, disp}, 16'h0000, "display off");
		disp_en <= 0;
		$display("test display done");
	endtask
	task t_learn(input logic [3:0] t_eod, input logic [15:0] exp);
		do_reset(0, 1, 1, 0);
		ticks(298, 18'sh00258);
		temp <= t_eod;
		eod <= 1;
		ticks(2, 18'sh00258);
		chk({15'h0000, vd_flag}, {15'h0000, t_eod == 4'h4}, "valid flag");
		eod <= 0;
		temp <= 4'h6;
		ticks(400, -18'sh003E8);
		chk(lc, exp, "learned");
		$display("test learning done");
	endtask
	task t_sat;
		do_reset(0, 1, 1, 1);
		ticks(65540, 18'sh00258);
		chk(dis_cnt, 16'hFFFF, "discharge count saturate");
		chk(ac, 16'h0000, "charge floor");
		$display("test saturation done");
	endtask
	initial begin
		t_full;
		t_dsg;
		t_disp;
		t_learn(4'h4, 16'h012C);
		t_learn(4'h3, `CAC_FULL_SZ_PH);
		t_sat;
		summarize;
	end
endmodule // test_cac_core
